/* File: src/pml_modulation_limiter.sv */
// Overview of operation
// - full-bridge bit 7 set: modulation spread equally over two pwm outputs
// - full-bridge mode halves both high and low limit offsets
// - applied duty never exceeds nominal plus 3-bit selected high offset
// - applied duty limited below by nominal minus 2-bit selected low offset, or by the high limit where that is lower
// - bit 2 is a read/write pulse-skipping enable
// - skipping on and loop duty below low limit: the pulse is dropped
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module pml_modulation_limiter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire pml_pkg::pml_duty_t loop_duty,
  output logic pwm_a,
  output logic pwm_b,
  output logic pulse_skipped
);
  import pml_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    pml_duty_t nominal;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    pml_duty_t cnt;
    pml_duty_t duty;
    logic skipped;
    logic pwm_a;
    logic pwm_b;
  } pml_state_s;

  pml_state_s s_r;
  pml_state_s s_nxt;

  pml_duty_t limit_hi;
  pml_duty_t limit_lo;

  logic [7:0] cfg_now;
  pml_duty_t nom_now;
  logic acc;
  logic addr_ok;
  logic [7:0] acc_idx;
  pml_duty_t cnt_n;
  pml_duty_t duty_n;
  pml_duty_t cnt_off;

  // limits follow the registered configuration one cycle later
  pml_limit_calc u_limit_calc (
    .hclk(hclk),
    .hresetn(hresetn),
    .full_bridge(s_r.cfg[PML_CFG_FB_BIT]),
    .hi_code(s_r.cfg[PML_CFG_HI_MSB:PML_CFG_HI_LSB]),
    .lo_code(s_r.cfg[PML_CFG_LO_MSB:PML_CFG_LO_LSB]),
    .nominal(s_r.nominal),
    .limit_hi(limit_hi),
    .limit_lo(limit_lo)
  );

  function automatic logic [31:0] read_word(
    input logic [7:0] idx,
    input logic [7:0] cfg,
    input pml_duty_t nom,
    input pml_duty_t hi,
    input pml_duty_t lo,
    input pml_duty_t duty,
    input logic skipped
  );
    logic [31:0] w;
    w = PML_RDATA_RST;
    unique case (idx)
      PML_CFG_IDX: begin
        w[7:0] = cfg;
      end
      PML_NOM_IDX: begin
        w[PML_DUTY_W-1:0] = nom;
      end
      PML_STAT_IDX: begin
        w[PML_STAT_SKIP_BIT] = skipped;
        w[PML_STAT_DUTY_LSB +: PML_DUTY_W] = duty;
        w[PML_STAT_LO_LSB +: PML_DUTY_W] = lo;
        w[PML_STAT_HI_LSB +: PML_DUTY_W] = hi;
      end
      default: begin
        w = PML_RDATA_RST;
      end
    endcase
    return w;
  endfunction

  always_comb begin
    s_nxt = s_r;

    // bus: zero wait states, always OKAY
    s_nxt.hreadyout = 1'b1;
    s_nxt.hresp = 1'b0;

    // data phase of a pending write lands now; reads in the same cycle see it
    cfg_now = s_r.cfg;
    nom_now = s_r.nominal;
    if (s_r.wr_pend) begin
      if (s_r.wr_idx == PML_CFG_IDX) begin
        // reserved bit 3 is kept at zero
        cfg_now = hwdata[7:0] & PML_CFG_WMASK;
      end else if (s_r.wr_idx == PML_NOM_IDX) begin
        nom_now = hwdata[PML_DUTY_W-1:0];
      end
    end
    s_nxt.cfg = cfg_now;
    s_nxt.nominal = nom_now;

    // address phase
    acc = hsel && htrans[1] && hready && (hsize == PML_HSIZE_WORD);
    addr_ok = (haddr[31:PML_IDX_MSB+1] == '0) && (haddr[PML_IDX_LSB-1:0] == '0);
    acc_idx = haddr[PML_IDX_MSB:PML_IDX_LSB];
    s_nxt.wr_pend = 1'b0;
    if (acc) begin
      s_nxt.wr_pend = hwrite && addr_ok;
      s_nxt.wr_idx = acc_idx;
      if (!hwrite) begin
        s_nxt.hrdata = addr_ok ? read_word(acc_idx, cfg_now, nom_now, limit_hi, limit_lo, s_r.duty, s_r.skipped)
                               : PML_RDATA_RST;
      end
    end

    // period counter; a new duty is taken only at the period boundary so a pulse is never cut short
    cnt_n = s_r.cnt + 8'h01;
    duty_n = s_r.duty;
    if (s_r.cnt == PML_CNT_LAST) begin
      if (loop_duty < limit_lo) begin
        if (s_r.cfg[PML_CFG_PS_BIT]) begin
          duty_n = PML_DUTY_RST;
          s_nxt.skipped = 1'b1;
        end else begin
          duty_n = limit_lo;
          s_nxt.skipped = 1'b0;
        end
      end else if (loop_duty > limit_hi) begin
        duty_n = limit_hi;
        s_nxt.skipped = 1'b0;
      end else begin
        duty_n = loop_duty;
        s_nxt.skipped = 1'b0;
      end
    end
    s_nxt.cnt = cnt_n;
    s_nxt.duty = duty_n;

    // full bridge: second output carries the same pulse in the second half period
    cnt_off = pml_duty_t'(cnt_n - PML_HALF);
    s_nxt.pwm_a = cnt_n < duty_n;
    s_nxt.pwm_b = s_r.cfg[PML_CFG_FB_BIT] && (cnt_n >= PML_HALF) && (cnt_off < duty_n);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.cfg <= PML_CFG_RST;
      s_r.nominal <= PML_NOM_RST;
      s_r.wr_pend <= 1'b0;
      s_r.wr_idx <= 8'h00;
      s_r.hrdata <= PML_RDATA_RST;
      s_r.hreadyout <= 1'b1;
      s_r.hresp <= 1'b0;
      s_r.cnt <= PML_CNT_RST;
      s_r.duty <= PML_DUTY_RST;
      s_r.skipped <= 1'b0;
      s_r.pwm_a <= 1'b0;
      s_r.pwm_b <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hreadyout;
  assign hrdata = s_r.hrdata;
  assign hresp = s_r.hresp;
  assign pwm_a = s_r.pwm_a;
  assign pwm_b = s_r.pwm_b;
  assign pulse_skipped = s_r.skipped;

  chk_single_b_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(s_r.cfg[PML_CFG_FB_BIT]) |-> !s_r.pwm_b)
    else $error("second output driven outside full-bridge mode");

  chk_bridge_b_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cfg[PML_CFG_FB_BIT] && s_r.cnt == (PML_HALF - 8'h01) && s_r.duty != PML_DUTY_RST |=> s_r.pwm_b)
    else $error("second output missing its half-period pulse");

  chk_duty_high: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST |=> s_r.duty <= $past(limit_hi))
    else $error("applied duty above high limit");

  chk_duty_low: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && !s_r.cfg[PML_CFG_PS_BIT] |=> s_r.duty >= $past(limit_lo))
    else $error("applied duty below low limit");

  chk_skip_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == PML_CFG_IDX |=> s_r.cfg[PML_CFG_PS_BIT] == $past(hwdata[PML_CFG_PS_BIT]))
    else $error("skip enable not written");

  chk_skip_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && s_r.cfg[PML_CFG_PS_BIT] && loop_duty < limit_lo
    |=> s_r.duty == PML_DUTY_RST && s_r.skipped && !s_r.pwm_a ##1 !s_r.pwm_a)
    else $error("pulse issued while skipping");

  chk_clamp_low: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && !s_r.cfg[PML_CFG_PS_BIT] && loop_duty < limit_lo
    |=> s_r.duty == $past(limit_lo) && !s_r.skipped)
    else $error("low duty not clamped to low limit");

  // bus side: every master is promised zero wait states and an OKAY response
  chk_ready_always: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout)
    else $error("wait state inserted");

  chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp)
    else $error("error response given");

  chk_cfg_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == PML_CFG_IDX |=> s_r.cfg == ($past(hwdata[7:0]) & PML_CFG_WMASK))
    else $error("configuration write lost");

  chk_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.cfg & ~PML_CFG_WMASK) == 8'h00)
    else $error("reserved configuration bit set");

  chk_nom_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.wr_pend && s_r.wr_idx == PML_NOM_IDX |=> s_r.nominal == $past(hwdata[PML_DUTY_W-1:0]))
    else $error("nominal write lost");

  // without a write in flight the settings must not drift
  chk_cfg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.wr_pend |=> s_r.cfg == $past(s_r.cfg) && s_r.nominal == $past(s_r.nominal))
    else $error("configuration changed without a write");

  chk_cfg_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && addr_ok && acc_idx == PML_CFG_IDX && !s_r.wr_pend
    |=> hrdata == {24'h00_0000, $past(s_r.cfg)})
    else $error("configuration read back wrong");

  chk_nom_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && addr_ok && acc_idx == PML_NOM_IDX && !s_r.wr_pend
    |=> hrdata == {24'h00_0000, $past(s_r.nominal)})
    else $error("nominal read back wrong");

  chk_status_read: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && addr_ok && acc_idx == PML_STAT_IDX
    |=> hrdata == {$past(limit_hi), $past(limit_lo), $past(s_r.duty), 7'h00, $past(s_r.skipped)})
    else $error("status read back wrong");

  chk_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && (!addr_ok || (acc_idx != PML_CFG_IDX && acc_idx != PML_NOM_IDX && acc_idx != PML_STAT_IDX))
    |=> hrdata == PML_RDATA_RST)
    else $error("unmapped read not zero");

  // the first edge after release still sees the reset count, so it is skipped
  chk_cnt_step: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> s_r.cnt == pml_duty_t'($past(s_r.cnt) + 8'h01))
    else $error("period counter skipped a step");

  chk_duty_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt != PML_CNT_LAST |=> s_r.duty == $past(s_r.duty) && s_r.skipped == $past(s_r.skipped))
    else $error("duty changed inside a period");

  chk_duty_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && loop_duty >= limit_lo && loop_duty <= limit_hi
    |=> s_r.duty == $past(loop_duty) && !s_r.skipped)
    else $error("in-range duty not passed through");

  chk_clamp_high: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && loop_duty > limit_hi |=> s_r.duty == $past(limit_hi) && !s_r.skipped)
    else $error("high duty not clamped to high limit");

  chk_skip_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt == PML_CNT_LAST && !(s_r.cfg[PML_CFG_PS_BIT] && loop_duty < limit_lo) |=> !s_r.skipped)
    else $error("skip flag raised for an issued pulse");

  chk_limits_ordered: assert property (@(posedge hclk) disable iff (!hresetn)
    limit_lo <= limit_hi)
    else $error("low limit above high limit");

  chk_bridge_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(s_r.cfg[PML_CFG_FB_BIT]) |-> limit_hi <= PML_HALF)
    else $error("bridge high limit above half period");

  // the second leg only ever fires in the second half of the period
  chk_b_late_half: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.cnt < PML_HALF |-> !s_r.pwm_b)
    else $error("second output fired in first half period");

  chk_a_follows_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    s_r.pwm_a == (s_r.cnt < s_r.duty))
    else $error("first output out of step with applied duty");

endmodule // pml_modulation_limiter

/* File: inc/pml_pkg.sv */
package pml_pkg;

  // duty is held in 1/256ths of the switching period
  localparam int PML_DUTY_W = 8;
  typedef logic [PML_DUTY_W-1:0] pml_duty_t;

  // register indices; byte address is four times the index
  localparam logic [7:0] PML_CFG_IDX = 8'h2E;
  localparam logic [7:0] PML_NOM_IDX = 8'h40;
  localparam logic [7:0] PML_STAT_IDX = 8'h41;
  localparam int PML_IDX_LSB = 2;
  localparam int PML_IDX_MSB = 9;

  // configuration register fields
  localparam int PML_CFG_FB_BIT = 7;
  localparam int PML_CFG_HI_MSB = 6;
  localparam int PML_CFG_HI_LSB = 4;
  localparam int PML_CFG_PS_BIT = 2;
  localparam int PML_CFG_LO_MSB = 1;
  localparam int PML_CFG_LO_LSB = 0;
  localparam logic [7:0] PML_CFG_WMASK = 8'hF7;
  localparam logic [7:0] PML_CFG_RST = 8'h00;
  localparam pml_duty_t PML_NOM_RST = 8'h80;

  // status register fields
  localparam int PML_STAT_SKIP_BIT = 0;
  localparam int PML_STAT_DUTY_LSB = 8;
  localparam int PML_STAT_LO_LSB = 16;
  localparam int PML_STAT_HI_LSB = 24;

  // offsets from nominal, in 1/256ths of the period
  localparam pml_duty_t PML_HI_OFF [0:7] = '{8'h20, 8'h40, 8'h50, 8'h60, 8'h70, 8'h78, 8'h7C, 8'h80};
  localparam pml_duty_t PML_LO_OFF [0:3] = '{8'h80, 8'h7C, 8'h78, 8'h70};

  localparam pml_duty_t PML_DUTY_MAX = 8'hFF;
  localparam pml_duty_t PML_HALF = 8'h80;
  localparam pml_duty_t PML_CNT_LAST = 8'hFF;
  localparam pml_duty_t PML_CNT_RST = 8'h00;
  localparam pml_duty_t PML_DUTY_RST = 8'h00;

  // bus constants
  localparam logic [2:0] PML_HSIZE_WORD = 3'h2;
  localparam logic [31:0] PML_RDATA_RST = 32'h0000_0000;

endpackage

/* File: src/pml_limit_calc.sv */
`timescale 1ns/1ps
module pml_limit_calc (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic full_bridge,
  input wire logic [2:0] hi_code,
  input wire logic [1:0] lo_code,
  input wire pml_pkg::pml_duty_t nominal,
  output pml_pkg::pml_duty_t limit_hi,
  output pml_pkg::pml_duty_t limit_lo
);
  import pml_pkg::*;

  typedef struct packed {
    pml_duty_t hi;
    pml_duty_t lo;
  } pml_calc_s;

  pml_calc_s s_r;
  pml_calc_s s_nxt;
  pml_duty_t off_hi;
  pml_duty_t off_lo;
  pml_duty_t cap;
  logic [PML_DUTY_W:0] sum;

  always_comb begin
    s_nxt = s_r;
    // full bridge halves both offsets
    off_hi = full_bridge ? (PML_HI_OFF[hi_code] >> 1) : PML_HI_OFF[hi_code];
    off_lo = full_bridge ? (PML_LO_OFF[lo_code] >> 1) : PML_LO_OFF[lo_code];
    // each bridge output may carry at most half a period
    cap = full_bridge ? PML_HALF : PML_DUTY_MAX;
    sum = {1'b0, nominal} + {1'b0, off_hi};
    s_nxt.hi = (sum > {1'b0, cap}) ? cap : sum[PML_DUTY_W-1:0];
    s_nxt.lo = (nominal < off_lo) ? PML_DUTY_RST : pml_duty_t'(nominal - off_lo);
    // a low limit above the high limit would let the clamp exceed the maximum
    if (s_nxt.lo > s_nxt.hi) begin
      s_nxt.lo = s_nxt.hi;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign limit_hi = s_r.hi;
  assign limit_lo = s_r.lo;

  chk_fb_half_high: assert property (@(posedge hclk) disable iff (!hresetn)
    full_bridge && nominal == PML_DUTY_RST |=> limit_hi == (PML_HI_OFF[$past(hi_code)] >> 1))
    else $error("full-bridge high limit not halved");

  chk_high_table: assert property (@(posedge hclk) disable iff (!hresetn)
    !full_bridge && nominal == PML_DUTY_RST |=> limit_hi == PML_HI_OFF[$past(hi_code)])
    else $error("high limit differs from table");

  chk_low_table: assert property (@(posedge hclk) disable iff (!hresetn)
    !full_bridge && nominal == PML_DUTY_MAX |=> limit_lo == pml_duty_t'(PML_DUTY_MAX - PML_LO_OFF[$past(lo_code)]))
    else $error("low limit differs from table");

endmodule // pml_limit_calc

/* File: verif/pml_power_stage.sv */
`timescale 1ns/1ps
// switch pair of the power stage: counts on-time of each leg while measure is high
module pml_power_stage (
  input wire logic hclk,
  input wire logic pwm_a,
  input wire logic pwm_b,
  input wire logic measure,
  output logic [31:0] on_a,
  output logic [31:0] on_b
);
  always @(posedge hclk) begin
    if (!measure) begin
      on_a <= 0;
      on_b <= 0;
    end else begin
      // an unknown leg level spoils the count instead of counting as off
      on_a <= on_a + {31'h0, pwm_a};
      on_b <= on_b + {31'h0, pwm_b};
    end
  end
endmodule // pml_power_stage

/* File: verif/pml_modulation_limiter_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module pml_modulation_limiter_bench;
  import pml_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, measure = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = PML_HSIZE_WORD;
  logic hreadyout, hresp, pwm_a, pwm_b, pulse_skipped;
  pml_duty_t loop_duty = 8'h00;
  logic [31:0] on_a, on_b;
  int n_errors = 0, n_tests = 0, cyc = 0;
  localparam logic [31:0] CFG_A = {22'h0, PML_CFG_IDX, 2'b00};
  localparam logic [31:0] NOM_A = {22'h0, PML_NOM_IDX, 2'b00};
  localparam logic [31:0] STAT_A = {22'h0, PML_STAT_IDX, 2'b00};
  always #10 hclk = ~hclk;
  pml_modulation_limiter dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .loop_duty(loop_duty), .pwm_a(pwm_a), .pwm_b(pwm_b), .pulse_skipped(pulse_skipped));
  pml_power_stage stage_u (.hclk(hclk), .pwm_a(pwm_a), .pwm_b(pwm_b), .measure(measure), .on_a(on_a), .on_b(on_b));
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ceiling well above the ~10400 cycles the scenarios need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic t_regs;
    bus(0, CFG_A, 0, q);
    `CHK("cfg reset", 32'h0000_0000, q)
    bus(0, NOM_A, 0, q);
    `CHK("nominal reset", 32'h0000_0080, q)
    bus(1, CFG_A, 32'hFFFF_FFFF, q);
    bus(0, CFG_A, 0, q);
    `CHK("cfg readback", 32'h0000_00F7, q)
    bus(1, CFG_A, 32'h0000_0004, q);
    bus(0, CFG_A, 0, q);
    `CHK("skip bit alone", 32'h0000_0004, q)
    bus(1, 32'h0000_0200, 32'hFFFF_FFFF, q);
    bus(0, 32'h0000_0200, 0, q);
    `CHK("unmapped read", 32'h0000_0000, q)
    `CHK("hresp okay", 1'b0, hresp)
  endtask
  // program, let two period boundaries pass, then measure one full period
  task automatic run(input logic [7:0] cfg, input logic [7:0] nom, input pml_duty_t ld,
                     input int ea, input int eb, input logic es, input logic [7:0] ehi);
    bus(1, CFG_A, {24'h0, cfg}, q);
    bus(1, NOM_A, {24'h0, nom}, q);
    @(posedge hclk);
    loop_duty <= ld;
    repeat (600) @(posedge hclk);
    measure <= 1'b1;
    repeat (256) @(posedge hclk);
    @(negedge hclk);
    `CHK("width a", ea, on_a)
    `CHK("width b", eb, on_b)
    `CHK("skip flag", es, pulse_skipped)
    measure <= 1'b0;
    bus(0, STAT_A, 0, q);
    `CHK("status high limit", ehi, q[31:24])
    `CHK("status skip", es, q[0])
  endtask
  task automatic t_high;
    run(8'h00, 8'h80, 8'hF0, 160, 0, 1'b0, 8'hA0);
    run(8'h70, 8'h80, 8'hFF, 255, 0, 1'b0, 8'hFF);
    run(8'h40, 8'h10, 8'h30, 48, 0, 1'b0, 8'h80);
    run(8'h10, 8'h00, 8'hFF, 64, 0, 1'b0, 8'h40);
  endtask
  task automatic t_low;
    run(8'h03, 8'h80, 8'h05, 16, 0, 1'b0, 8'hA0);
    run(8'h07, 8'h80, 8'h05, 0, 0, 1'b1, 8'hA0);
    run(8'h01, 8'h80, 8'h05, 5, 0, 1'b0, 8'hA0);
    run(8'h03, 8'hFF, 8'h00, 143, 0, 1'b0, 8'hFF);
  endtask
  task automatic t_bridge;
    run(8'h90, 8'h40, 8'h70, 96, 96, 1'b0, 8'h60);
    run(8'h83, 8'h40, 8'h02, 8, 8, 1'b0, 8'h50);
    run(8'h87, 8'h40, 8'h02, 0, 0, 1'b1, 8'h50);
    run(8'hF0, 8'h00, 8'hFF, 64, 64, 1'b0, 8'h40);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_high();
    t_low();
    t_bridge();
    report_and_stop();
  end
endmodule // pml_modulation_limiter_bench
